// [hw/cgc_global_config.sv]
// Global configuration of the universal counter with an Avalon-MM register slave.
`default_nettype none

module cgc_global_config #(
  parameter int CNT_W = 32
) (
  input  wire logic                           i_core_clk,
  input  wire logic                           i_sys_rst,
  // Avalon-MM slave.
  input  wire logic [4:0]                     i_avs_address,
  input  wire logic                           i_avs_read,
  input  wire logic                           i_avs_write,
  input  wire logic [31:0]                    i_avs_writedata,
  input  wire logic [3:0]                     i_avs_byteenable,
  output logic      [31:0]                    o_avs_readdata,
  output logic                                o_avs_waitrequest,
  // Signal inputs and channel paths.
  input  wire logic                           i_input1,
  input  wire logic                           i_input2,
  output logic                                o_chan1,
  output logic                                o_chan2,
  // Timebase selection and rear reference connector.
  input  wire logic                           i_int_osc,
  input  wire logic                           i_ref_pin_in,
  output logic                                o_ref_pin_out,
  output logic                                o_ref_pin_oe_n,
  output logic                                o_timebase,
  output logic                                o_timebase_ext,
  // Attenuators and automatic trigger.
  input  wire logic [cgc_pkg::NUM_INPUTS-1:0] i_amp_high,
  output logic      [cgc_pkg::NUM_INPUTS-1:0] o_tenfold_attenuator,
  // Measurement function and gate sequencing.
  input  wire cgc_pkg::cgc_func_t             i_func,
  output logic                                o_interval_delay_apply,
  output logic                                o_gate_open,
  output logic                                o_result_strobe,
  output logic      [6:0]                     o_gates_per_result,
  output logic      [3:0]                     o_display_digits
);
  import cgc_pkg::*;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);

  // ----------------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------------
  // Number of decades in the gate time gives the displayed digit count.
  function automatic logic [3:0] digits_of(input logic [31:0] gate);
    logic [3:0]  n;
    logic [31:0] dec;
    n   = 4'h1;
    dec = 32'h0000_000A;
    for (int i = 0; i < 9; i++) begin
      if (gate >= dec) begin
        n = n + 4'h1;
      end
      dec = dec * 32'h0000_000A;
    end
    return n;
  endfunction

  function automatic logic [31:0] merge_be(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------------------
  logic ack_q;
  wire  req      = i_avs_read | i_avs_write;
  wire  wr_fire  = i_avs_write & ack_q;
  wire  rd_take  = i_avs_read & ~ack_q;

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  assign o_avs_waitrequest = req & ~ack_q;

  // ----------------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------------
  logic [CTRL_WIDTH-1:0] ctrl_q;
  logic [CTRL_WIDTH-1:0] ctrl_d;
  logic [2:0]            atten_q;
  logic [31:0]           resol_q;
  logic [31:0]           gate_q;
  logic [31:0]           rdata_q;

  wire wr_ctrl  = wr_fire & (i_avs_address == OFS_CTRL);
  wire wr_atten = wr_fire & (i_avs_address == OFS_ATTEN);
  wire wr_resol = wr_fire & (i_avs_address == OFS_RESOL);
  wire wr_gate  = wr_fire & (i_avs_address == OFS_GATE);
  wire wr_total = wr_fire & (i_avs_address == OFS_TOTAL);

  wire [31:0] ctrl_wv  = merge_be({23'h0, ctrl_q}, i_avs_writedata, i_avs_byteenable);
  wire [31:0] resol_wv = merge_be(resol_q, i_avs_writedata, i_avs_byteenable);
  wire        automatic_trigger_level = ctrl_q[CTRL_AUTOMATIC_TRIGGER_LEVEL_LEVEL];
  wire        avg_on    = ctrl_q[CTRL_AVERAGING];
  wire        tb_ext    = ctrl_q[CTRL_TIMEBASE_EXT];
  wire        fine_req  = wr_resol & (resol_wv < FINE_RESOL_PS) & ~avg_on;

  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d = ctrl_wv[CTRL_WIDTH-1:0];
    end
    if (ctrl_d[CTRL_TIMEBASE_EXT]) begin
      ctrl_d[CTRL_TB_OUT_EN] = 1'b0;
    end
    if (fine_req) begin
      ctrl_d[CTRL_AVERAGING] = 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      ctrl_q  <= CTRL_RESET;
      resol_q <= RESOL_RESET;
      gate_q  <= GATE_RESET;
    end else begin
      ctrl_q <= ctrl_d;
      if (wr_resol) begin
        resol_q <= resol_wv;
      end
      if (wr_gate) begin
        gate_q <= merge_be(gate_q, i_avs_writedata, i_avs_byteenable);
      end
    end
  end

  // Automatic trigger level drives the attenuators and locks out writes.
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      atten_q <= ATTEN_RESET;
    end else if (automatic_trigger_level) begin
      atten_q <= i_amp_high;
    end else if (wr_atten && i_avs_byteenable[0]) begin
      atten_q <= i_avs_writedata[2:0];
    end
  end

  assign o_tenfold_attenuator = atten_q;

  // ----------------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------------
  wire [3:0]  digits_w = digits_of(gate_q);
  wire [31:0] status_w = {25'h0, o_ref_pin_oe_n == 1'b0, tb_ext, avg_on, digits_w};
  logic [CNT_W-1:0] tot_count;
  logic [31:0]      rsel;

  always_comb begin
    case (i_avs_address)
      OFS_CTRL:   rsel = {23'h0, ctrl_q};
      OFS_ATTEN:  rsel = {29'h0, atten_q};
      OFS_RESOL:  rsel = resol_q;
      OFS_GATE:   rsel = gate_q;
      OFS_STATUS: rsel = status_w;
      OFS_TOTAL:  rsel = 32'(tot_count);
      default:    rsel = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_take) begin
      rdata_q <= rsel;
    end
  end

  assign o_avs_readdata   = rdata_q;
  assign o_display_digits = digits_w;

  // ----------------------------------------------------------------------------
  // Routing and timebase
  // ----------------------------------------------------------------------------
  logic chan1_q;
  logic chan2_q;
  logic tb_q;
  logic ref_out_q;
  wire  shared = ctrl_q[CTRL_SHARED_ROUTING];

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      chan1_q   <= 1'b0;
      chan2_q   <= 1'b0;
      tb_q      <= 1'b0;
      ref_out_q <= 1'b0;
    end else begin
      chan1_q   <= i_input1;
      chan2_q   <= shared ? i_input1 : i_input2;
      tb_q      <= tb_ext ? i_ref_pin_in : i_int_osc;
      ref_out_q <= i_int_osc;
    end
  end

  assign o_chan1        = chan1_q;
  assign o_chan2        = chan2_q;
  assign o_timebase     = tb_q;
  assign o_timebase_ext = tb_ext;
  assign o_ref_pin_out  = ref_out_q;
  assign o_ref_pin_oe_n = ~(ctrl_q[CTRL_TB_OUT_EN] & ~tb_ext);
  assign o_interval_delay_apply = ctrl_q[CTRL_INTERVAL_DELAY]
                                  & (i_func == CGC_FN_TIME_INTERVAL);

  // ----------------------------------------------------------------------------
  // Gate sequencing and averaging
  // ----------------------------------------------------------------------------
  logic [31:0] gate_cnt_q;
  logic [6:0]  period_q;
  logic        strobe_q;
  wire  [6:0]  periods = avg_on ? 7'(AVG_GATES) : 7'(SINGLE_GATES);
  wire         gate_end = (gate_cnt_q + 32'h1 >= gate_q);
  wire         last_period = (period_q + 7'h1 >= periods);

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      gate_cnt_q <= 32'h0;
      period_q   <= 7'h0;
      strobe_q   <= 1'b0;
    end else begin
      strobe_q   <= gate_end & last_period;
      gate_cnt_q <= gate_end ? 32'h0 : gate_cnt_q + 32'h1;
      if (gate_end) begin
        period_q <= last_period ? 7'h0 : period_q + 7'h1;
      end
    end
  end

  assign o_gate_open        = 1'b1;
  assign o_result_strobe    = strobe_q;
  assign o_gates_per_result = periods;

  // ----------------------------------------------------------------------------
  // Gated totalize
  // ----------------------------------------------------------------------------
  logic [1:0] in_level;
  logic [1:0] in_rise;
  cgc_tot_if #(.CNT_W(CNT_W)) tot_bus ();

  cgc_sync #(.W(2)) u_sync (
    .i_core_clk (i_core_clk),
    .i_sys_rst  (i_sys_rst),
    .i_async    ({shared ? i_input1 : i_input2, i_input1}),
    .o_level    (in_level),
    .o_rise     (in_rise)
  );

  wire cnt_in2 = ctrl_q[CTRL_COUNT_ON_INPUT2];
  assign tot_bus.enable          = ctrl_q[CTRL_GATED_TOTALIZE] & (i_func == CGC_FN_TOTALIZE);
  assign tot_bus.gate_active_low = ctrl_q[CTRL_GATE_ACTIVE_LOW];
  assign tot_bus.event_edge      = cnt_in2 ? in_rise[1] : in_rise[0] ;
  assign tot_bus.gate_level      = cnt_in2 ? in_level[0] : in_level[1];
  assign tot_bus.clear           = wr_total;
  assign tot_count               = tot_bus.count;

  cgc_totalizer #(.CNT_W(CNT_W)) u_tot (
    .i_core_clk (i_core_clk),
    .i_sys_rst  (i_sys_rst),
    .tot        (tot_bus)
  );

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  AST_SHARED_ROUTE: assert property (shared |=> (chan2_q == $past(i_input1)))
    else $error("Shared routing did not feed input one to channel two.");
  AST_INDEP_ROUTE: assert property (!shared |=> (chan2_q == $past(i_input2)))
    else $error("Independent routing did not use input two.");
  AST_INT_TB: assert property (!tb_ext |=> (tb_q == $past(i_int_osc)))
    else $error("Onboard timebase not selected.");
  AST_EXT_FORCES_OFF: assert property (tb_ext |-> !ctrl_q[CTRL_TB_OUT_EN])
    else $error("Timebase output left on with external timebase.");
  AST_REF_DRIVE: assert property (!o_ref_pin_oe_n |-> ctrl_q[CTRL_TB_OUT_EN])
    else $error("Reference connector driven while output disabled.");
  AST_ATTEN_LOCK: assert property ((automatic_trigger_level && wr_atten) |=>
    (atten_q == $past(i_amp_high)))
    else $error("Manual attenuator write accepted during automatic trigger.");
  AST_DELAY_TI_ONLY: assert property ((i_func != CGC_FN_TIME_INTERVAL) |->
    !o_interval_delay_apply) else $error("Interval delay applied outside time interval.");
  AST_AVG_PERIODS: assert property (avg_on |-> (o_gates_per_result == 7'h64))
    else $error("Averaging does not span one hundred gates.");
  AST_SINGLE_SHOT: assert property (!avg_on |-> (o_gates_per_result == 7'h01))
    else $error("Single shot does not use one gate.");
  AST_AUTO_AVG: assert property (fine_req |=> avg_on ##1 avg_on)
    else $error("Fine resolution request did not turn averaging on.");
  AST_DIGITS: assert property ((gate_q == GATE_RESET) |-> (o_display_digits == 4'h5))
    else $error("Digit count does not follow gate time.");
endmodule

`default_nettype wire

// [hw/cgc_pkg.sv]
// Package of constants and types for the counter global configuration block.
`default_nettype none

package cgc_pkg;

  // ----------------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------------
  localparam logic [4:0] OFS_CTRL   = 5'h00;
  localparam logic [4:0] OFS_ATTEN  = 5'h04;
  localparam logic [4:0] OFS_RESOL  = 5'h08;
  localparam logic [4:0] OFS_GATE   = 5'h0C;
  localparam logic [4:0] OFS_STATUS = 5'h10;
  localparam logic [4:0] OFS_TOTAL  = 5'h14;

  // ----------------------------------------------------------------------------
  // Control register field positions
  // ----------------------------------------------------------------------------
  localparam int CTRL_SHARED_ROUTING   = 0;
  localparam int CTRL_TIMEBASE_EXT     = 1;
  localparam int CTRL_TB_OUT_EN        = 2;
  localparam int CTRL_INTERVAL_DELAY   = 3;
  localparam int CTRL_AVERAGING        = 4;
  localparam int CTRL_GATE_ACTIVE_LOW  = 5;
  localparam int CTRL_GATED_TOTALIZE   = 6;
  localparam int CTRL_COUNT_ON_INPUT2  = 7;
  localparam int CTRL_AUTOMATIC_TRIGGER_LEVEL_LEVEL  = 8;
  localparam int CTRL_WIDTH            = 9;

  // ----------------------------------------------------------------------------
  // Status register field positions
  // ----------------------------------------------------------------------------
  localparam int STAT_DIGITS_LSB = 0;
  localparam int STAT_AVG_ACTIVE = 4;
  localparam int STAT_TB_EXT     = 5;
  localparam int STAT_TB_DRIVEN  = 6;

  // ----------------------------------------------------------------------------
  // Reset values and measurement constants
  // ----------------------------------------------------------------------------
  localparam logic [CTRL_WIDTH-1:0] CTRL_RESET  = 9'h000;
  localparam logic [2:0]            ATTEN_RESET = 3'h0;
  localparam logic [31:0]           RESOL_RESET = 32'h0000_2710;
  localparam logic [31:0]           GATE_RESET  = 32'h0000_2710;
  localparam int                    AVG_GATES   = 100;
  localparam int                    SINGLE_GATES = 1;
  localparam int                    AVG_RESOL_PS  = 100;
  localparam int                    FINE_RESOL_NS = 1;
  localparam logic [31:0]           FINE_RESOL_PS = 32'(FINE_RESOL_NS * 1000);
  localparam int                    NUM_INPUTS  = 3;

  typedef enum logic [1:0] {
    CGC_FN_OTHER,
    CGC_FN_TIME_INTERVAL,
    CGC_FN_TOTALIZE
  } cgc_func_t;

endpackage

`default_nettype wire

// [hw/cgc_sync.sv]
// Two-stage synchroniser with rising edge detection for a group of inputs.
`default_nettype none

module cgc_sync #(
  parameter int W = 2
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_sys_rst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_level,
  output logic      [W-1:0] o_rise
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign o_level = sync_q;
  assign o_rise  = sync_q & ~prev_q;
endmodule

`default_nettype wire

// [hw/cgc_tot_if.sv]
// Interface carrying gate, event and count between the main block and the totalizer.
`default_nettype none

interface cgc_tot_if #(parameter int CNT_W = 32);
  logic             enable;
  logic             gate_active_low;
  logic             gate_level;
  logic             event_edge;
  logic             clear;
  logic [CNT_W-1:0] count;

  modport ctrl (output enable, gate_active_low, gate_level, event_edge, clear, input count);
  modport tot  (input enable, gate_active_low, gate_level, event_edge, clear, output count);
endinterface

`default_nettype wire

// [hw/cgc_totalizer.sv]
// Gated event totalizer that accumulates while the qualified gate is active.
`default_nettype none

module cgc_totalizer #(
  parameter int CNT_W = 32
) (
  input  wire logic  i_core_clk,
  input  wire logic  i_sys_rst,
  cgc_tot_if.tot     tot
);
  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;
  wire              gate_open = tot.gate_level ^ tot.gate_active_low;
  wire              bump      = tot.enable & gate_open & tot.event_edge;

  // A clear in the same cycle as an event keeps that event.
  assign count_d = tot.clear ? CNT_W'(bump) : count_q + CNT_W'(bump);

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  assign tot.count = count_q;

  AST_TOT_GATED: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (!tot.clear && !(tot.gate_level ^ tot.gate_active_low)) |=> $stable(count_q))
    else $error("Totalizer counted while the gate was closed.");
  AST_TOT_STEP: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (!tot.clear && tot.enable && tot.event_edge && (tot.gate_level ^ ~tot.gate_active_low)
     == 1'b0) |=> (count_q == $past(count_q) + CNT_W'(1)))
    else $error("Totalizer missed a gated event edge.");
endmodule

`default_nettype wire

// [verif/cgc_global_config_tb.sv]
// Self-checking testbench of the counter global configuration block.
`default_nettype none

module cgc_global_config_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cgc_pkg::*;

  logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, l1 = 1'b0, l2 = 1'b0;
  logic [4:0] adr = 5'h00;
  logic [31:0] wd = 32'h0, rdat, q;
  logic wreq, in1, in2, osc, rf, ch1, ch2, rpo, rpoe_n, tb, tbx, dly, gop, stb;
  logic [2:0] amp = 3'h0, att;
  logic [6:0] gpr;
  logic [3:0] dig;
  cgc_func_t fn = CGC_FN_OTHER;
  int error_cnt = 0, check_count = 0, cyc = 0;

  always #5 clk = ~clk;

  cgc_source_model i_src (.i_core_clk(clk), .i_lvl1(l1), .i_lvl2(l2), .o_input1(in1),
    .o_input2(in2), .o_int_osc(osc), .o_ref(rf));

  cgc_global_config i_dut (.i_core_clk(clk), .i_sys_rst(rst), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hF),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .i_input1(in1), .i_input2(in2),
    .o_chan1(ch1), .o_chan2(ch2), .i_int_osc(osc), .i_ref_pin_in(rf), .o_ref_pin_out(rpo),
    .o_ref_pin_oe_n(rpoe_n), .o_timebase(tb), .o_timebase_ext(tbx), .i_amp_high(amp),
    .o_tenfold_attenuator(att), .i_func(fn), .o_interval_delay_apply(dly),
    .o_gate_open(gop), .o_result_strobe(stb), .o_gates_per_result(gpr),
    .o_display_digits(dig));

  task automatic results();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      error_cnt++;
      results();
    end
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // One Avalon-MM transfer, held until waitrequest is seen low at a rising edge.
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    rd <= ~w;
    wr <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    if (wreq !== 1'b0) begin
      error_cnt++;
      $display("[FAIL] %0t bus transfer never completed", $time);
    end
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic rchk(input logic [4:0] a, input logic [31:0] e, input string what);
    bus(1'b0, a, 32'h0);
    cmp(q, e, what);
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic t_reset();
    rchk(OFS_CTRL, 32'h0, "ctrl reset");
    rchk(OFS_RESOL, 32'h0000_2710, "resolution reset");
    rchk(OFS_GATE, 32'h0000_2710, "gate reset");
    rchk(OFS_STATUS, 32'h0000_0005, "status reset");
    rchk(5'h18, 32'h0, "unmapped");
    cmp(32'(gpr), 32'(SINGLE_GATES), "single gates");
    cmp(32'(gop), 32'h0000_0001, "gate open");
  endtask

  task automatic t_route();
    logic [1:0] exp [4];
    logic [1:0] lv [4];
    lv = '{2'b01, 2'b10, 2'b10, 2'b01};
    exp = '{2'b01, 2'b10, 2'b00, 2'b11};
    for (int i = 0; i < 4; i++) begin
      if (i == 2) bus(1'b1, OFS_CTRL, 32'h1);
      @(posedge clk);
      l2 <= lv[i][1];
      l1 <= lv[i][0];
      settle(3);
      cmp({ch2, ch1}, exp[i], "routing");
    end
    bus(1'b1, OFS_CTRL, 32'h0);
  endtask

  task automatic tbchk(input logic ext, input logic oen);
    logic prev;
    @(negedge clk);
    prev = ext ? rf : osc;
    for (int i = 0; i < 12; i++) begin
      @(negedge clk);
      cmp(tb, prev, "timebase source");
      if (!oen) cmp(rpo, prev, "reference out");
      prev = ext ? rf : osc;
    end
    cmp({tbx, rpoe_n}, {ext, oen}, "connector enable");
  endtask

  task automatic t_timebase();
    tbchk(1'b0, 1'b1);
    bus(1'b1, OFS_CTRL, 32'h4);
    tbchk(1'b0, 1'b0);
    bus(1'b1, OFS_CTRL, 32'h6);
    rchk(OFS_CTRL, 32'h2, "output forced off");
    tbchk(1'b1, 1'b1);
    bus(1'b1, OFS_CTRL, 32'h0);
  endtask

  task automatic t_atten();
    bus(1'b1, OFS_ATTEN, 32'h5);
    rchk(OFS_ATTEN, 32'h5, "atten read");
    settle(2);
    cmp(32'(att), 32'h5, "atten manual");
    @(posedge clk);
    amp <= 3'h2;
    bus(1'b1, OFS_CTRL, 32'h100);
    bus(1'b1, OFS_ATTEN, 32'h7);
    settle(4);
    cmp(32'(att), 32'h2, "atten automatic");
    bus(1'b1, OFS_CTRL, 32'h0);
  endtask

  task automatic t_delay();
    cgc_func_t f [3];
    f = '{CGC_FN_OTHER, CGC_FN_TIME_INTERVAL, CGC_FN_TOTALIZE};
    for (int e = 0; e < 2; e++) begin
      bus(1'b1, OFS_CTRL, e ? 32'h8 : 32'h0);
      for (int i = 0; i < 3; i++) begin
        @(posedge clk);
        fn <= f[i];
        settle(2);
        cmp(32'(dly), 32'(e == 1 && i == 1), "interval delay");
      end
    end
  endtask

  task automatic gap(input int exp);
    int n;
    n = 0;
    settle(1);
    while (stb !== 1'b1 && n < 600) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (stb !== 1'b1 && n < 600);
    cmp(32'(n), 32'(exp), "strobe spacing");
  endtask

  task automatic t_average();
    bus(1'b1, OFS_GATE, 32'h5);
    gap(5);
    bus(1'b1, OFS_CTRL, 32'h10);
    settle(2);
    cmp(32'(gpr), 32'(AVG_GATES), "averaged gates");
    gap(5 * AVG_GATES);
    bus(1'b1, OFS_CTRL, 32'h0);
    bus(1'b1, OFS_RESOL, 32'h0000_03E8);
    rchk(OFS_STATUS, 32'h0000_0001, "resolution 1000 keeps single");
    bus(1'b1, OFS_RESOL, 32'h0000_03E7);
    rchk(OFS_STATUS, 32'h0000_0011, "resolution 999 averages");
    bus(1'b1, OFS_CTRL, 32'h0);
  endtask

  task automatic t_digits();
    logic [31:0] g [4];
    logic [3:0] d [4];
    g = '{32'h0000_0009, 32'h0000_000A, 32'h0000_0063, 32'h3B9A_CA00};
    d = '{4'h1, 4'h2, 4'h2, 4'hA};
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, OFS_GATE, g[i]);
      settle(2);
      cmp(32'(dig), 32'(d[i]), "digits");
    end
    bus(1'b1, OFS_GATE, 32'h5);
  endtask

  task automatic pulse(input int n, input logic two);
    repeat (n) begin
      @(posedge clk);
      if (two) l2 <= 1'b1;
      else l1 <= 1'b1;
      repeat (4) @(posedge clk);
      if (two) l2 <= 1'b0;
      else l1 <= 1'b0;
      repeat (4) @(posedge clk);
    end
    settle(6);
  endtask

  task automatic t_total();
    bus(1'b1, OFS_CTRL, 32'h40);
    @(posedge clk);
    fn <= CGC_FN_TOTALIZE;
    l1 <= 1'b0;
    l2 <= 1'b1;
    bus(1'b1, OFS_TOTAL, 32'h0);
    pulse(3, 1'b0);
    rchk(OFS_TOTAL, 32'h3, "gate high counts");
    @(posedge clk);
    l2 <= 1'b0;
    pulse(2, 1'b0);
    rchk(OFS_TOTAL, 32'h3, "gate low holds");
    bus(1'b1, OFS_CTRL, 32'h60);
    pulse(2, 1'b0);
    rchk(OFS_TOTAL, 32'h5, "complemented_gate gate counts");
    bus(1'b1, OFS_CTRL, 32'hC0);
    @(posedge clk);
    l1 <= 1'b1;
    pulse(1, 1'b1);
    rchk(OFS_TOTAL, 32'h6, "input two counted");
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_route();
    t_timebase();
    t_atten();
    t_delay();
    t_average();
    t_digits();
    t_total();
    results();
  end
endmodule

`default_nettype wire

// [verif/cgc_source_model.sv]
// Behavioural model of the signal sources and reference oscillators beside the block.
`default_nettype none

module cgc_source_model (
  input  wire logic i_core_clk,
  input  wire logic i_lvl1,
  input  wire logic i_lvl2,
  output logic      o_input1,
  output logic      o_input2,
  output logic      o_int_osc,
  output logic      o_ref
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] cnt_q = 4'h0;

  always @(posedge i_core_clk) begin
    cnt_q <= cnt_q + 4'h1;
  end

  // The two references run at unlike rates so that a wrong source selection shows.
  assign o_int_osc = cnt_q[2];
  assign o_ref     = cnt_q[0] ^ cnt_q[3];
  assign o_input1  = i_lvl1;
  assign o_input2  = i_lvl2;
endmodule

`default_nettype wire
